// >>> rtl/card_tx_pkg.sv
// shared constants and types for the smart card transmit control block
package card_tx_pkg;
   localparam int ADDR_W = 18;
   // register indices; byte address is four times the index
   localparam logic [15:0] IDX_TX_CTRL = 16'hfe06;
   localparam logic [15:0] IDX_TX_BYTE = 16'hfe07;
   localparam logic [15:0] IDX_RX_CTRL = 16'hfe08;
   localparam logic [15:0] IDX_CFG = 16'hfe10;
   localparam logic [15:0] IDX_IRQ_STATUS = 16'hfe11;
   localparam logic [15:0] IDX_IRQ_CLEAR = 16'hfe12;
   localparam logic [15:0] IDX_IRQ_ENABLE = 16'hfe13;
   // card_tx_control_status fields, plus RX_FINAL of the receive control register
   localparam int CT_SYNC_STOP = 7;
   localparam int CT_FINAL = 2;
   localparam int CT_DIR = 1;
   localparam int RX_FINAL = 5;
   // configuration fields
   localparam int CF_SYNC_MODE = 0;
   localparam int CF_HALT_EN = 1;
   localparam int CF_T1 = 2;
   localparam int CF_CHECK_EN = 3;
   localparam int CF_CRC_SEL = 4;
   localparam int CF_SW_IO = 5;
   // interrupt bits
   localparam int IRQ_EVENT = 0;
   localparam int IRQ_ERROR = 1;
   // reset values and the CRC polynomial
   localparam logic [7:0] TX_CTRL_RST = 8'h00;
   localparam logic [7:0] RX_CTRL_RST = 8'h00;
   localparam logic [7:0] CFG_RST = 8'h00;
   localparam logic [1:0] IRQ_EN_RST = 2'h0;
   localparam logic [15:0] CRC_INIT = 16'hffff;
   localparam logic [15:0] CRC_POLY = 16'h1021;
   localparam logic [7:0] LRC_INIT = 8'h00;
   // timing counts, queue depth and AXI response codes
   localparam int ETU_CYCLES_DEFAULT = 372;
   localparam int FRAME_BITS = 10;
   localparam int GUARD_ETUS = 2;
   localparam int FIFO_DEPTH_DEFAULT = 2;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [1:0] {TX_IDLE, TX_BITS, TX_GUARD} tx_state_t;

   function automatic logic [15:0] crc_step(input logic [15:0] crc, input logic [7:0] b);
      logic [15:0] c;
      c = crc ^ {b, 8'h00};
      for (int i = 0; i < 8; i++) begin
         c = c[15] ? ((c << 1) ^ CRC_POLY) : (c << 1);
      end
      return c;
   endfunction : crc_step
endpackage : card_tx_pkg

// >>> rtl/tx_byte_fifo.sv
// transmit byte queue held in flip-flops
`timescale 1ns/1ps
`default_nettype none
module tx_byte_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 2
) (
   input wire logic sys_clk, // system clock
   input wire logic sys_rst, // async reset, high
   input wire logic push, // store push_data
   input wire logic [WIDTH-1:0] push_data, // byte to store
   input wire logic pop, // advance read pointer
   output logic [WIDTH-1:0] head, // oldest entry
   output logic full, // queue full
   output logic empty // queue empty
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

   typedef struct packed {
      logic [AW:0] wr_ptr;
      logic [AW:0] rd_ptr;
      logic [DEPTH-1:0][WIDTH-1:0] mem;
   } fifo_state_t;

   fifo_state_t q, d;

   // pointers carry one extra wrap bit, so full and empty need no counter
   assign empty = (q.wr_ptr == q.rd_ptr);
   assign full = (q.wr_ptr[AW-1:0] == q.rd_ptr[AW-1:0]) && (q.wr_ptr[AW] != q.rd_ptr[AW]);
   assign head = q.mem[q.rd_ptr[AW-1:0]];

   always_comb begin
      d = q;
      // a push into a full queue is dropped; old entries are never erased
      if (push && !full) begin
         d.mem[q.wr_ptr[AW-1:0]] = push_data;
         d.wr_ptr = q.wr_ptr + 1'b1;
      end
      if (pop && !empty) begin
         d.rd_ptr = q.rd_ptr + 1'b1;
      end
   end

   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end
endmodule : tx_byte_fifo
`default_nettype wire

// >>> rtl/smartcard_tx_control.sv
// smart card transmit control with AXI4-Lite registers
// Behaviour
// - sync stop mode halts card clock at terminal
// - sync stop at count limit: I/O follows software bit
// - full flag tracks queue; going full interrupts
// - empty flag mirrors queue; queued bytes transmitted
// - T=1 final: empty waits for check bytes
// - T=0 final: empty after last character succeeds
// - going empty raises transmit event interrupt
// - underflow when queue drains without final flag
// - underflow clears on read, raises error interrupt
// - final flag set after last byte; check appended
// - direction bit selects transmit or receive
// - direction set or clear restarts check logic
// - final set: switch to receive once empty
// - card break sets flag, clears on read
// - data register write queues byte for card
// - data register read advances read pointer
`timescale 1ns/1ps
`default_nettype none
module smartcard_tx_control
   import card_tx_pkg::*;
#(
   parameter int ETU_CYCLES = ETU_CYCLES_DEFAULT,
   parameter int FIFO_DEPTH = FIFO_DEPTH_DEFAULT
) (
   input wire logic sys_clk, // 50 MHz clock
   input wire logic sys_rst, // async reset, high
   input wire logic [ADDR_W-1:0] s_axi_awaddr, // write address
   input wire logic s_axi_awvalid, // write address valid
   output logic s_axi_awready, // write address ready
   input wire logic [31:0] s_axi_wdata, // write data
   input wire logic [3:0] s_axi_wstrb, // byte enables
   input wire logic s_axi_wvalid, // write data valid
   output logic s_axi_wready, // write data ready
   output logic [1:0] s_axi_bresp, // write response
   output logic s_axi_bvalid, // write response valid
   input wire logic s_axi_bready, // write response ready
   input wire logic [ADDR_W-1:0] s_axi_araddr, // read address
   input wire logic s_axi_arvalid, // read address valid
   output logic s_axi_arready, // read address ready
   output logic [31:0] s_axi_rdata, // read data
   output logic [1:0] s_axi_rresp, // read response
   output logic s_axi_rvalid, // read data valid
   input wire logic s_axi_rready, // read data ready
   input wire logic ext_card_io_line_in, // card I/O pin level
   output logic ext_card_io_line_out, // card I/O drive value
   output logic ext_card_io_line_oe_n, // low while pulling pin low
   input wire logic rlen_terminal, // repetition counter terminal pulse
   input wire logic rlen_at_limit, // repetition count at max or zero
   input wire logic [7:0] rx_status, // receive side status bits
   output logic final_rx_byte_flag, // receive last-byte flag
   output logic direction_select, // effective direction, 1 transmit
   output logic card_clock_stop, // stop the card clock
   output logic irq // level interrupt
);
   localparam int ETU_W = $clog2(ETU_CYCLES + 1);
   localparam logic [ETU_W-1:0] ETU_LAST = ETU_W'(ETU_CYCLES - 1);
   localparam logic [ETU_W-1:0] ETU_HALF = ETU_W'(ETU_CYCLES / 2);
   localparam logic [3:0] BIT_LAST = 4'(FRAME_BITS - 1);
   localparam logic [3:0] GUARD_LAST = 4'(GUARD_ETUS - 1);

   typedef struct packed {
      logic aw_held;
      logic [15:0] aw_idx;
      logic w_held;
      logic [7:0] w_data;
      logic w_strb0;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [7:0] rdata;
      logic [1:0] rresp;
      logic sync_stop;
      logic final_tx;
      logic dir;
      logic final_rx;
      logic underflow;
      logic brk;
      logic [7:0] cfg;
      logic [1:0] irq_status;
      logic [1:0] irq_enable;
      logic irq;
      logic tx_mode;
      tx_state_t state;
      logic [9:0] shift;
      logic [3:0] bit_cnt;
      logic [ETU_W-1:0] etu_cnt;
      logic [7:0] byte_q;
      logic is_check;
      logic [1:0] check_idx;
      logic brk_seen;
      logic [15:0] crc;
      logic [7:0] lrc;
      logic full_prev;
      logic empty_prev;
      logic line_low;
      logic clk_halt;
      logic io_meta;
      logic io_sync;
   } ctl_state_t;

   ctl_state_t q, d;
   logic fifo_push;
   logic fifo_pop;
   logic [7:0] fifo_head;
   logic fifo_full;
   logic fifo_empty;
   logic rd_pop;
   logic rd_ctrl;
   logic tx_pop;
   logic reinit;
   logic [1:0] irq_clr;
   logic under_evt;
   logic brk_evt;
   logic check_pending;
   logic empty_flag;
   logic override;
   logic tick;
   logic ld;
   logic [7:0] nb;
   logic [7:0] ctrl_view;

   tx_byte_fifo #(
      .WIDTH(8),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .sys_clk(sys_clk),
      .sys_rst(sys_rst),
      .push(fifo_push),
      .push_data(q.w_data),
      .pop(fifo_pop),
      .head(fifo_head),
      .full(fifo_full),
      .empty(fifo_empty)
   );

   assign s_axi_awready = !q.aw_held;
   assign s_axi_wready = !q.w_held;
   assign s_axi_bvalid = q.bvalid;
   assign s_axi_bresp = q.bresp;
   assign s_axi_arready = !q.rvalid;
   assign s_axi_rvalid = q.rvalid;
   assign s_axi_rresp = q.rresp;
   assign s_axi_rdata = {24'h000000, q.rdata};
   assign ext_card_io_line_out = 1'b0;
   assign ext_card_io_line_oe_n = !q.line_low;
   assign final_rx_byte_flag = q.final_rx;
   assign direction_select = q.tx_mode;
   assign card_clock_stop = q.clk_halt;
   assign irq = q.irq;
   assign fifo_pop = rd_pop | tx_pop;

   always_comb begin
      d = q;
      fifo_push = 1'b0;
      rd_pop = 1'b0;
      rd_ctrl = 1'b0;
      tx_pop = 1'b0;
      reinit = 1'b0;
      irq_clr = 2'h0;
      under_evt = 1'b0;
      brk_evt = 1'b0;
      ld = 1'b0;
      nb = 8'h00;
      tick = (q.etu_cnt == ETU_LAST);
      override = q.sync_stop && rlen_at_limit;
      check_pending = q.cfg[CF_T1] && q.cfg[CF_CHECK_EN] && q.final_tx
         && (q.check_idx < (q.cfg[CF_CRC_SEL] ? 2'd2 : 2'd1));
      // with the final flag set, empty also waits for the last frame and check bytes
      empty_flag = fifo_empty && !(q.final_tx && ((q.state != TX_IDLE) || check_pending));
      ctrl_view = {q.sync_stop, 1'b0, fifo_full, empty_flag, q.underflow, q.final_tx, q.dir, q.brk};

      d.io_meta = ext_card_io_line_in;
      d.io_sync = q.io_meta;

      // write channel
      if (q.bvalid && s_axi_bready) begin
         d.bvalid = 1'b0;
         d.aw_held = 1'b0;
         d.w_held = 1'b0;
      end
      if (s_axi_awvalid && !q.aw_held) begin
         d.aw_held = 1'b1;
         d.aw_idx = s_axi_awaddr[ADDR_W-1:2];
      end
      if (s_axi_wvalid && !q.w_held) begin
         d.w_held = 1'b1;
         d.w_data = s_axi_wdata[7:0];
         d.w_strb0 = s_axi_wstrb[0];
      end
      if (q.aw_held && q.w_held && !q.bvalid) begin
         d.bvalid = 1'b1;
         d.bresp = RESP_OKAY;
         case (q.aw_idx)
            IDX_TX_CTRL: begin
               if (q.w_strb0) begin
                  d.sync_stop = q.w_data[CT_SYNC_STOP];
                  d.final_tx = q.w_data[CT_FINAL];
                  d.dir = q.w_data[CT_DIR];
                  reinit = (q.w_data[CT_DIR] != q.dir);
               end
            end
            IDX_TX_BYTE: fifo_push = q.w_strb0;
            IDX_RX_CTRL: begin
               if (q.w_strb0) begin
                  d.final_rx = q.w_data[RX_FINAL];
               end
            end
            IDX_CFG: begin
               if (q.w_strb0) begin
                  d.cfg = q.w_data;
               end
            end
            IDX_IRQ_CLEAR: irq_clr = q.w_data[1:0] & {2{q.w_strb0}};
            IDX_IRQ_ENABLE: begin
               if (q.w_strb0) begin
                  d.irq_enable = q.w_data[1:0];
               end
            end
            IDX_IRQ_STATUS: d.bresp = RESP_OKAY;
            default: d.bresp = RESP_SLVERR;
         endcase
      end

      // read channel
      if (q.rvalid && s_axi_rready) begin
         d.rvalid = 1'b0;
      end
      if (s_axi_arvalid && !q.rvalid) begin
         d.rvalid = 1'b1;
         d.rresp = RESP_OKAY;
         d.rdata = 8'h00;
         case (s_axi_araddr[ADDR_W-1:2])
            IDX_TX_CTRL: begin
               d.rdata = ctrl_view;
               rd_ctrl = 1'b1;
            end
            IDX_TX_BYTE: begin
               d.rdata = fifo_head;
               rd_pop = !fifo_empty;
            end
            IDX_RX_CTRL: d.rdata = {rx_status[7:6], q.final_rx, rx_status[4:0]};
            IDX_CFG: d.rdata = q.cfg;
            IDX_IRQ_STATUS: d.rdata = {6'h00, q.irq_status};
            IDX_IRQ_ENABLE: d.rdata = {6'h00, q.irq_enable};
            IDX_IRQ_CLEAR: d.rdata = 8'h00;
            default: d.rresp = RESP_SLVERR;
         endcase
      end

      // finish the message before leaving transmit when the final flag is set
      d.tx_mode = q.dir || (q.tx_mode && q.final_tx && !empty_flag);

      // character transmitter
      unique case (q.state)
         TX_IDLE: begin
            if (q.tx_mode && !override && !rd_pop) begin
               if (!fifo_empty) begin
                  tx_pop = 1'b1;
                  ld = 1'b1;
                  nb = fifo_head;
                  d.is_check = 1'b0;
                  d.crc = crc_step(q.crc, fifo_head);
                  d.lrc = q.lrc ^ fifo_head;
               end else if (check_pending) begin
                  ld = 1'b1;
                  if (!q.cfg[CF_CRC_SEL]) begin
                     nb = q.lrc;
                  end else if (q.check_idx == 2'd0) begin
                     nb = q.crc[15:8];
                  end else begin
                     nb = q.crc[7:0];
                  end
                  d.is_check = 1'b1;
                  d.check_idx = q.check_idx + 2'd1;
               end
            end
            if (ld) begin
               d.byte_q = nb;
               d.shift = {^nb, nb, 1'b0};
               d.bit_cnt = 4'h0;
               d.etu_cnt = '0;
               d.state = TX_BITS;
            end
         end
         TX_BITS: begin
            d.etu_cnt = q.etu_cnt + 1'b1;
            if (tick) begin
               d.etu_cnt = '0;
               if (q.bit_cnt == BIT_LAST) begin
                  d.state = TX_GUARD;
                  d.bit_cnt = 4'h0;
                  d.brk_seen = 1'b0;
               end else begin
                  d.shift = {1'b1, q.shift[9:1]};
                  d.bit_cnt = q.bit_cnt + 4'h1;
               end
            end
         end
         TX_GUARD: begin
            d.etu_cnt = q.etu_cnt + 1'b1;
            // the card pulls the line low in the guard time to signal a parity error
            if (q.bit_cnt == 4'h0 && q.etu_cnt == ETU_HALF && !q.io_sync) begin
               d.brk_seen = 1'b1;
            end
            if (tick) begin
               d.etu_cnt = '0;
               if (q.bit_cnt == GUARD_LAST) begin
                  d.bit_cnt = 4'h0;
                  if (q.brk_seen) begin
                     brk_evt = 1'b1;
                     d.shift = {^q.byte_q, q.byte_q, 1'b0};
                     d.state = TX_BITS;
                  end else begin
                     d.state = TX_IDLE;
                     under_evt = !q.is_check && fifo_empty && !q.final_tx;
                  end
               end else begin
                  d.bit_cnt = q.bit_cnt + 4'h1;
               end
            end
         end
      endcase

      if (!q.final_tx) begin
         d.check_idx = 2'd0;
      end
      if (reinit) begin
         d.crc = CRC_INIT;
         d.lrc = LRC_INIT;
         d.check_idx = 2'd0;
      end

      d.line_low = override ? !q.cfg[CF_SW_IO] : (d.state == TX_BITS && !d.shift[0]);
      d.clk_halt = q.cfg[CF_SYNC_MODE] && q.sync_stop && q.cfg[CF_HALT_EN]
         && (q.clk_halt || rlen_terminal);

      // flags: a new event wins over the clear on read
      d.underflow = (q.underflow && !rd_ctrl) || under_evt;
      d.brk = (q.brk && !rd_ctrl) || brk_evt;
      d.full_prev = fifo_full;
      d.empty_prev = empty_flag;
      d.irq_status = q.irq_status & ~irq_clr;
      if (fifo_full && !q.full_prev) begin
         d.irq_status[IRQ_EVENT] = 1'b1;
      end
      if (empty_flag && !q.empty_prev) begin
         d.irq_status[IRQ_EVENT] = 1'b1;
      end
      if (under_evt || brk_evt) begin
         d.irq_status[IRQ_ERROR] = 1'b1;
      end
      d.irq = |(d.irq_status & d.irq_enable);
   end

   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         q <= '0;
         q.sync_stop <= TX_CTRL_RST[CT_SYNC_STOP];
         q.final_tx <= TX_CTRL_RST[CT_FINAL];
         q.dir <= TX_CTRL_RST[CT_DIR];
         q.final_rx <= RX_CTRL_RST[RX_FINAL];
         q.cfg <= CFG_RST;
         q.irq_enable <= IRQ_EN_RST;
         q.crc <= CRC_INIT;
         q.lrc <= LRC_INIT;
         q.empty_prev <= 1'b1;
         q.io_meta <= 1'b1;
         q.io_sync <= 1'b1;
         q.state <= TX_IDLE;
      end else begin
         q <= d;
      end
   end
endmodule : smartcard_tx_control
`default_nettype wire

// >>> testbench/smartcard_tx_control_sva.sv
// port checker for the smart card transmit block
`timescale 1ns/1ps
`default_nettype none
module smartcard_tx_control_sva
   import card_tx_pkg::*;
#(
   parameter int ETU_CYCLES = ETU_CYCLES_DEFAULT,
   parameter int FIFO_DEPTH = FIFO_DEPTH_DEFAULT
) (
   input wire logic sys_clk, // clock
   input wire logic sys_rst, // reset
   input wire logic s_axi_awvalid, // aw valid
   input wire logic s_axi_awready, // aw ready
   input wire logic s_axi_wvalid, // w valid
   input wire logic s_axi_wready, // w ready
   input wire logic [1:0] s_axi_bresp, // b resp
   input wire logic s_axi_bvalid, // b valid
   input wire logic s_axi_bready, // b ready
   input wire logic s_axi_arvalid, // ar valid
   input wire logic s_axi_arready, // ar ready
   input wire logic [31:0] s_axi_rdata, // r data
   input wire logic s_axi_rvalid, // r valid
   input wire logic s_axi_rready, // r ready
   input wire logic ext_card_io_line_oe_n, // line pull
   input wire logic rlen_terminal, // terminal pulse
   input wire logic rlen_at_limit, // count at limit
   input wire logic direction_select, // direction
   input wire logic card_clock_stop, // clock stop
   input wire logic irq // interrupt
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (sys_rst);
   int low_q;
   // cycles the line is held low
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) low_q <= 0;
      else low_q <= ext_card_io_line_oe_n ? 0 : low_q + 1;
   end
   reset_state_a: assert property ($fell(sys_rst) |-> !irq && ext_card_io_line_oe_n && !direction_select
      && !card_clock_stop) else $error("outputs not idle after reset");
   write_resp_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |-> ##[1:3] s_axi_bvalid) else $error("write response missing");
   bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped");
   aw_blocked_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write taken while response pending");
   read_latency_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read data late");
   rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped");
   rdata_upper_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
      else $error("read data upper bits set");
   bit_length_a: assert property ($rose(ext_card_io_line_oe_n) && !rlen_at_limit
      |-> low_q > 0 && low_q % ETU_CYCLES == 0) else $error("low stretch not whole bit times");
   clock_stop_a: assert property ($rose(card_clock_stop)
      |-> $past(rlen_terminal) || $past(rlen_terminal, 2)) else $error("clock stopped without terminal count");
endmodule : smartcard_tx_control_sva
`default_nettype wire

// >>> testbench/card_model.sv
// card model on the open-drain I/O line
`timescale 1ns/1ps
`default_nettype none
module card_model #(
   parameter int ETU = 8
) (
   input wire logic sys_clk, // clock
   input wire logic sys_rst, // reset, high
   input wire logic drive_low_n, // low while the reader pulls the line
   input wire logic nak_req, // refuse the next character
   output logic line, // line level, pulled up when released
   output logic [7:0] got_q, // last character data
   output logic got_ok_q, // start low and parity even
   output int got_n_q // characters seen
);
   logic busy_q;
   logic nak_q;
   logic [9:0] sh_q;
   int cnt_q;
   assign line = drive_low_n & ~nak_q;
   always @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         busy_q <= 1'h0;
         nak_q <= 1'h0;
         got_n_q <= 0;
         cnt_q <= 0;
      end else if (!busy_q) begin
         busy_q <= ~line;
         cnt_q <= 1;
      end else begin
         cnt_q <= cnt_q + 1;
         if (cnt_q % ETU == ETU / 2 && cnt_q < 10 * ETU) sh_q <= {line, sh_q[9:1]};
         if (cnt_q == 10 * ETU) begin
            got_q <= sh_q[8:1];
            got_ok_q <= ~sh_q[0] & ~(^sh_q[9:1]);
            got_n_q <= got_n_q + 1;
            nak_q <= nak_req;
         end
         if (cnt_q == 11 * ETU) nak_q <= 1'h0;
         if (cnt_q == 12 * ETU - 1) busy_q <= 1'h0;
      end
   end
endmodule : card_model
`default_nettype wire

// >>> testbench/smartcard_tx_control_test.sv
// self-checking bench for the smart card transmit control block
`timescale 1ns/1ps
`default_nettype none
module smartcard_tx_control_test;
   import card_tx_pkg::*;
   localparam int ETU = 8;
   logic sys_clk = 1'h0, sys_rst = 1'h1;
   logic [ADDR_W-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
   logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, s_axi_arvalid = 1'h0;
   logic s_axi_rready = 1'h0, rlen_terminal = 1'h0, rlen_at_limit = 1'h0, nak_req = 1'h0;
   logic [31:0] s_axi_wdata = '0, s_axi_rdata, rd;
   logic [3:0] s_axi_wstrb = 4'h1;
   logic [7:0] rx_status = 8'h00, got;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, got_ok;
   logic [1:0] s_axi_bresp, s_axi_rresp, rs;
   logic ext_card_io_line_in, ext_card_io_line_out, ext_card_io_line_oe_n;
   logic final_rx_byte_flag, direction_select, card_clock_stop, irq;
   int got_n, failures = 0, samples_checked = 0, cycles = 0;
   smartcard_tx_control #(.ETU_CYCLES(ETU), .FIFO_DEPTH(2)) uut (.*);
   card_model #(.ETU(ETU)) card (.sys_clk(sys_clk), .sys_rst(sys_rst), .drive_low_n(ext_card_io_line_oe_n),
      .nak_req(nak_req), .line(ext_card_io_line_in), .got_q(got), .got_ok_q(got_ok), .got_n_q(got_n));
   initial begin
      forever #10 sys_clk = ~sys_clk;
   end
   always @(posedge sys_clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         failures = failures + 1;
         close_out();
      end
   end
   task automatic close_out();
      $display("compared %0d mismatches %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : close_out
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] seen);
      samples_checked++;
      if (seen !== exp) begin
         failures++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   task automatic wr(input logic [15:0] idx, input logic [7:0] d, input logic [1:0] er = RESP_OKAY);
      logic aw, w;
      @(posedge sys_clk);
      s_axi_awaddr <= {idx, 2'h0};
      s_axi_wdata <= {24'h0, d};
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      forever begin
         @(negedge sys_clk);
         if (!s_axi_awvalid && !s_axi_wvalid) break;
         aw = s_axi_awvalid & s_axi_awready;
         w = s_axi_wvalid & s_axi_wready;
         @(posedge sys_clk);
         if (aw) s_axi_awvalid <= 1'h0;
         if (w) s_axi_wvalid <= 1'h0;
      end
      while (!s_axi_bvalid) @(negedge sys_clk);
      chk("write response", {30'h0, er}, {30'h0, s_axi_bresp});
      @(posedge sys_clk);
      s_axi_bready <= 1'h1;
      @(posedge sys_clk);
      s_axi_bready <= 1'h0;
   endtask : wr
   task automatic rd_reg(input logic [15:0] idx);
      @(posedge sys_clk);
      s_axi_araddr <= {idx, 2'h0};
      s_axi_arvalid <= 1'h1;
      do @(negedge sys_clk); while (!s_axi_arready);
      @(posedge sys_clk);
      s_axi_arvalid <= 1'h0;
      do @(negedge sys_clk); while (!s_axi_rvalid);
      rd = s_axi_rdata;
      rs = s_axi_rresp;
      @(posedge sys_clk);
      s_axi_rready <= 1'h1;
      @(posedge sys_clk);
      s_axi_rready <= 1'h0;
   endtask : rd_reg
   task automatic expect_reg(input logic [15:0] idx, input logic [7:0] e, input string what);
      rd_reg(idx);
      chk(what, {24'h0, e}, rd);
   endtask : expect_reg
   task automatic pin(input string what, input logic e, input logic seen);
      @(negedge sys_clk);
      chk(what, {31'h0, e}, {31'h0, seen});
   endtask : pin
   // waits for one character, checks data and framing
   task automatic await_char(input logic [7:0] e, input string what);
      int n0;
      n0 = got_n;
      do @(posedge sys_clk); while (got_n == n0);
      chk(what, {23'h0, 1'h1, e}, {23'h0, got_ok, got});
   endtask : await_char
   task automatic t_regs();
      expect_reg(IDX_TX_CTRL, 8'h10, "ctrl reset");
      expect_reg(IDX_IRQ_ENABLE, 8'h00, "enable reset");
      wr(IDX_RX_CTRL, 8'h20);
      pin("rx final", 1'h1, final_rx_byte_flag);
      wr(16'hfe0f, 8'h55, RESP_SLVERR);
      rd_reg(16'hfe0f);
      chk("unmapped read", {RESP_SLVERR, 30'h0}, {rs, rd[29:0]});
   endtask : t_regs
   task automatic t_fill();
      wr(IDX_IRQ_ENABLE, 8'h03);
      wr(IDX_TX_BYTE, 8'h5a);
      wr(IDX_TX_BYTE, 8'hc3);
      expect_reg(IDX_TX_CTRL, 8'h20, "ctrl full");
      expect_reg(IDX_IRQ_STATUS, 8'h01, "event on full");
      pin("irq raised", 1'h1, irq);
      wr(IDX_IRQ_CLEAR, 8'h01);
      pin("irq cleared", 1'h0, irq);
      wr(IDX_TX_BYTE, 8'h77);
      expect_reg(IDX_TX_BYTE, 8'h5a, "first pop");
      expect_reg(IDX_TX_BYTE, 8'hc3, "second pop");
      expect_reg(IDX_TX_CTRL, 8'h10, "ctrl drained");
      expect_reg(IDX_IRQ_STATUS, 8'h01, "event on empty");
      wr(IDX_IRQ_CLEAR, 8'h03);
   endtask : t_fill
   task automatic t_send();
      wr(IDX_TX_BYTE, 8'ha5);
      wr(IDX_TX_CTRL, 8'h02);
      pin("transmit selected", 1'h1, direction_select);
      await_char(8'ha5, "sent byte");
      repeat (2 * ETU + 4) @(posedge sys_clk);
      expect_reg(IDX_TX_CTRL, 8'h1a, "underflow");
      expect_reg(IDX_TX_CTRL, 8'h12, "underflow cleared");
      expect_reg(IDX_IRQ_STATUS, 8'h03, "error and event");
      wr(IDX_TX_CTRL, 8'h00);
      wr(IDX_IRQ_CLEAR, 8'h03);
   endtask : t_send
   task automatic t_nak();
      wr(IDX_TX_BYTE, 8'h3c);
      wr(IDX_TX_CTRL, 8'h04);
      nak_req <= 1'h1;
      wr(IDX_TX_CTRL, 8'h06);
      expect_reg(IDX_TX_CTRL, 8'h06, "t0 empty held");
      await_char(8'h3c, "refused byte");
      nak_req <= 1'h0;
      wr(IDX_TX_CTRL, 8'h04);
      pin("direction held", 1'h1, direction_select);
      await_char(8'h3c, "resent byte");
      repeat (2 * ETU + 4) @(posedge sys_clk);
      pin("direction released", 1'h0, direction_select);
      expect_reg(IDX_TX_CTRL, 8'h15, "break flag");
      expect_reg(IDX_TX_CTRL, 8'h14, "break cleared");
      expect_reg(IDX_IRQ_STATUS, 8'h03, "break irq");
      wr(IDX_TX_CTRL, 8'h00);
      wr(IDX_IRQ_CLEAR, 8'h03);
   endtask : t_nak
   task automatic t_t1(input logic crc);
      logic [15:0] c;
      c = CRC_INIT ^ {8'h31, 8'h00};
      for (int i = 0; i < 8; i++) c = c[15] ? ((c << 1) ^ CRC_POLY) : (c << 1);
      wr(IDX_CFG, {3'h0, crc, 4'hc});
      wr(IDX_TX_BYTE, 8'h31);
      wr(IDX_TX_CTRL, 8'h04);
      wr(IDX_TX_CTRL, 8'h06);
      await_char(8'h31, "t1 data");
      expect_reg(IDX_TX_CTRL, 8'h06, "t1 empty held");
      if (crc) begin
         await_char(c[15:8], "crc high");
         await_char(c[7:0], "crc low");
      end else await_char(LRC_INIT ^ 8'h31, "lrc");
      repeat (2 * ETU + 4) @(posedge sys_clk);
      expect_reg(IDX_TX_CTRL, 8'h16, "t1 done");
      wr(IDX_TX_CTRL, 8'h00);
      wr(IDX_CFG, 8'h00);
   endtask : t_t1
   task automatic t_sync();
      wr(IDX_CFG, 8'h23);
      wr(IDX_TX_CTRL, 8'h80);
      rlen_at_limit <= 1'h1;
      @(posedge sys_clk);
      rlen_terminal <= 1'h1;
      @(posedge sys_clk);
      rlen_terminal <= 1'h0;
      repeat (2) @(posedge sys_clk);
      pin("clock halted", 1'h1, card_clock_stop);
      pin("line follows set bit", 1'h1, ext_card_io_line_oe_n);
      wr(IDX_CFG, 8'h03);
      pin("line follows clear bit", 1'h0, ext_card_io_line_oe_n);
      wr(IDX_CFG, 8'h23);
      pin("line released", 1'h1, ext_card_io_line_oe_n);
      @(posedge sys_clk);
      rlen_at_limit <= 1'h0;
      wr(IDX_TX_CTRL, 8'h00);
      wr(IDX_CFG, 8'h00);
      pin("clock resumed", 1'h0, card_clock_stop);
   endtask : t_sync
   initial begin
      repeat (8) @(posedge sys_clk);
      sys_rst <= 1'h0;
      t_regs();
      t_fill();
      t_send();
      t_nak();
      t_t1(1'h1);
      t_t1(1'h0);
      t_sync();
      close_out();
   end
endmodule : smartcard_tx_control_test
bind smartcard_tx_control smartcard_tx_control_sva #(.ETU_CYCLES(ETU_CYCLES), .FIFO_DEPTH(FIFO_DEPTH)) chk_i (.*);
`default_nettype wire
